//--- rtl/spi_port_pkg.sv
package spi_port_pkg;
  // ==========================================================================
  // Register indices (printed offsets 21h..23h kept as word indices)
  localparam logic [1:0] IDX_DATA    = 2'h1;
  localparam logic [1:0] IDX_CONTROL = 2'h2;
  localparam logic [1:0] IDX_CSR     = 2'h3;

  // ==========================================================================
  // Control register fields
  localparam int CR_IRQ_EN   = 7;
  localparam int CR_PORT_OE  = 6;
  localparam int CR_HALF_DIV = 5;
  localparam int CR_MASTER   = 4;
  localparam int CR_CLOCK_POLARITY     = 3;
  localparam int CR_CLOCK_PHASE     = 2;
  localparam int CR_RATE_HI  = 1;
  localparam int CR_RATE_LO  = 0;

  // ==========================================================================
  // Control/status register fields
  localparam int CS_DONE     = 7;
  localparam int CS_WRITE_COLLISION_FLAG     = 6;
  localparam int CS_OVR      = 5;
  localparam int CS_MODE_FAULT_FLAG     = 4;
  localparam int CS_OUT_DIS  = 2;
  localparam int CS_SOFT_MGT = 1;
  localparam int CS_SOFT_LVL = 0;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CSR_RESET     = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic [3:0] BIT_COUNT     = 4'h8;

  // Half-periods of SCK in clk_sys cycles, minus one, per divider code
  localparam logic [5:0] HALF_DIV4   = 6'h01;
  localparam logic [5:0] HALF_DIV8   = 6'h03;
  localparam logic [5:0] HALF_DIV16  = 6'h07;
  localparam logic [5:0] HALF_DIV32  = 6'h0F;
  localparam logic [5:0] HALF_DIV64  = 6'h1F;
  localparam logic [5:0] HALF_DIV128 = 6'h3F;
endpackage

//--- rtl/spi_port.sv
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
// Behaviour
// - With irq enable set, done, mode fault or overrun raise the interrupt.
// - Port output enable resets to zero, gates pins, cleared on mode fault.
// - Master select drives SCK and swaps data pins; cleared by mode fault.
// - Master SCK divisors /4,/8,/16,/32,/64,/128 by half divider and rate bits.
// - Divider and rate bits have no effect in slave mode.
// - Clock polarity sets SCK idle level in both modes.
// - Clock phase 0 captures on first edge, 1 on second edge.
// - Done flag set at byte end; cleared by status access then data access.
// - While done is set, data writes are ignored until status is read or written.
// - Write collision flag set when data written during a transfer.
// - Overrun set when new byte completes while done is still set.
// - Mode fault set when select goes low in master mode.
// - Mode fault clears by control access while set, then control write.
// - Output disable stops driving MOSI as master or MISO as slave.
// - Soft select management uses soft level instead of the select pin.
// - Soft select level 0 selects, 1 deselects.
// - In master mode a data write while idle and not blocked starts one byte exchange.
// - Received byte copied to read buffer at end unless done is still set; reads return the buffer.
// - Data write loads the shift register directly.
// - Slave completion wakes from halt; extra bytes before clear set overrun.
// - Done, mode fault and overrun share one request; only done gives the halt wake.
// - A colliding write is dropped and the transfer continues.
module spi_port
(
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            irq,
  output logic            halt_wake,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe,
  input  wire logic       select_n_in,
  output logic            port_active
);

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_LEAD = 3'b010,
    ST_TRAIL = 3'b100
  } xfer_state_e;

  // ==========================================================================
  // Registers
  logic [7:0]  spi_control;
  logic [7:0]  csr_sw;
  logic        done_flag;
  logic        write_collision_flag_flag;
  logic        ovr_flag;
  logic        mode_fault_flag_flag;
  logic [7:0]  read_buf;
  logic [7:0]  shift_reg;
  logic        csr_seen;
  logic        mode_fault_flag_seen;
  xfer_state_e state;
  logic [3:0]  bit_cnt;
  logic [5:0]  div_cnt;
  logic        sample_bit;
  logic        sck_int;

  // ==========================================================================
  // Pin synchronisers
  logic [2:0] sck_sync;
  logic [1:0] mosi_sync;
  logic [1:0] ssn_sync;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sck_sync  <= 3'h0;
      mosi_sync <= 2'h0;
      ssn_sync  <= 2'h3;
    end
    else
    begin
      sck_sync  <= {sck_sync[1:0], sck_in};
      mosi_sync <= {mosi_sync[0], mosi_in};
      ssn_sync  <= {ssn_sync[0], select_n_in};
    end
  end

  // ==========================================================================
  // Decode
  wire enabled   = spi_control[spi_port_pkg::CR_PORT_OE];
  wire is_master = spi_control[spi_port_pkg::CR_MASTER];
  wire clock_polarity      = spi_control[spi_port_pkg::CR_CLOCK_POLARITY];
  wire clock_phase      = spi_control[spi_port_pkg::CR_CLOCK_PHASE];
  wire soft_mgt  = csr_sw[spi_port_pkg::CS_SOFT_MGT];
  wire sel_n     = soft_mgt ? csr_sw[spi_port_pkg::CS_SOFT_LVL] : ssn_sync[1];
  wire busy      = (state != ST_IDLE);

  wire acc_data = (reg_wr | reg_rd) && reg_addr == spi_port_pkg::IDX_DATA;
  wire acc_ctrl = (reg_wr | reg_rd) && reg_addr == spi_port_pkg::IDX_CONTROL;
  wire wr_ctrl  = reg_wr && reg_addr == spi_port_pkg::IDX_CONTROL;
  wire rd_csr   = reg_rd && reg_addr == spi_port_pkg::IDX_CSR;
  wire acc_csr  = (reg_wr | reg_rd) && reg_addr == spi_port_pkg::IDX_CSR;
  wire wr_csr   = reg_wr && reg_addr == spi_port_pkg::IDX_CSR;
  wire wr_data  = reg_wr && reg_addr == spi_port_pkg::IDX_DATA;

  // writes blocked while done set and status not yet read or written
  wire wr_blocked = done_flag && !csr_seen;
  wire collide    = wr_data && busy && !wr_blocked;
  wire load       = wr_data && !busy && !wr_blocked;

  wire mode_fault_flag_event = enabled && is_master && !sel_n;

  // divider selection; only read in master mode
  logic [5:0] half_div;
  always_comb
  begin
    case ({spi_control[spi_port_pkg::CR_HALF_DIV],
           spi_control[spi_port_pkg::CR_RATE_HI:spi_port_pkg::CR_RATE_LO]})
      3'b100:  half_div = spi_port_pkg::HALF_DIV4;
      3'b000:  half_div = spi_port_pkg::HALF_DIV8;
      3'b001:  half_div = spi_port_pkg::HALF_DIV16;
      3'b110:  half_div = spi_port_pkg::HALF_DIV32;
      3'b010:  half_div = spi_port_pkg::HALF_DIV64;
      default: half_div = spi_port_pkg::HALF_DIV128;
    endcase
  end

  // ==========================================================================
  // Serial edge events
  wire m_tick    = is_master && busy && div_cnt == half_div;
  wire s_sel     = enabled && !is_master && !sel_n;
  wire s_rise    = sck_sync[1] && !sck_sync[2];
  wire s_fall    = !sck_sync[1] && sck_sync[2];
  // idle level; leading edge is capture when phase is 0
  wire s_lead    = s_sel && (clock_polarity ? s_fall : s_rise);
  wire s_trail   = s_sel && (clock_polarity ? s_rise : s_fall);
  wire lead_ev   = is_master ? (m_tick && state == ST_LEAD) : s_lead;
  wire trail_ev  = is_master ? (m_tick && state == ST_TRAIL) : s_trail;
  wire capture   = clock_phase ? trail_ev : lead_ev;
  wire shift_ev  = clock_phase ? lead_ev : trail_ev;
  // Master MISO is launched by our own SCK, same clock, so no synchroniser delay
  wire serial_in = is_master ? miso_in : mosi_sync[1];
  wire last_edge = trail_ev && bit_cnt == spi_port_pkg::BIT_COUNT - 4'h1;
  wire complete  = last_edge;
  // Phase 1 keeps the first bit on the line through the first leading edge
  wire first_lead = state == ST_IDLE || bit_cnt == 4'h0;

  // ==========================================================================
  // Transfer engine
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      div_cnt    <= 6'h00;
      shift_reg  <= spi_port_pkg::DATA_RESET;
      sample_bit <= 1'b0;
      sck_int    <= 1'b0;
    end
    else
    begin
      div_cnt <= m_tick || !busy ? 6'h00 : div_cnt + 6'h01;
      if (load)
      begin
        shift_reg <= reg_wdata;
        bit_cnt   <= 4'h0;
      end
      else if (shift_ev && !(clock_phase == 1'b0 && last_edge) && !(clock_phase && first_lead))
        shift_reg <= {shift_reg[6:0], sample_bit};
      if (capture)
        sample_bit <= serial_in;
      case (state)
        ST_IDLE:
        begin
          sck_int <= 1'b0;
          if ((load && is_master && enabled) || s_lead)
          begin
            state <= s_lead ? ST_TRAIL : ST_LEAD;
            if (s_lead)
              bit_cnt <= 4'h0;
          end
        end
        ST_LEAD:
        begin
          if (!enabled)
            state <= ST_IDLE;
          else if (lead_ev)
          begin
            sck_int <= 1'b1;
            state   <= ST_TRAIL;
          end
        end
        ST_TRAIL:
        begin
          if (!enabled || (!is_master && sel_n && clock_phase == 1'b0 && !s_trail))
            state <= sel_n && !is_master ? ST_IDLE : state;
          if (!enabled)
            state <= ST_IDLE;
          else if (trail_ev)
          begin
            sck_int <= 1'b0;
            bit_cnt <= bit_cnt + 4'h1;
            state   <= complete ? ST_IDLE : ST_LEAD;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Final capture bit joins the shifted byte
  // Phase 1 captures the last bit on the completing edge itself
  wire [7:0] rx_byte = clock_phase ? {shift_reg[6:0], serial_in}
                            : {shift_reg[6:0], sample_bit};

  // ==========================================================================
  // Software registers and flags
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      spi_control <= spi_port_pkg::CONTROL_RESET;
      csr_sw      <= spi_port_pkg::CSR_RESET;
      done_flag   <= 1'b0;
      write_collision_flag_flag   <= 1'b0;
      ovr_flag    <= 1'b0;
      mode_fault_flag_flag   <= 1'b0;
      read_buf    <= spi_port_pkg::DATA_RESET;
      csr_seen    <= 1'b0;
      mode_fault_flag_seen   <= 1'b0;
    end
    else
    begin
      if (wr_csr)
        csr_sw <= {5'h00, reg_wdata[spi_port_pkg::CS_OUT_DIS:spi_port_pkg::CS_SOFT_LVL]};
      // Status access only counts while a flag it clears is pending
      csr_seen <= acc_data ? 1'b0 : (acc_csr && (done_flag || write_collision_flag_flag) ? 1'b1 : csr_seen);
      mode_fault_flag_seen <= acc_ctrl && mode_fault_flag_flag ? 1'b1 : mode_fault_flag_seen && mode_fault_flag_flag;
      if (wr_ctrl)
      begin
        spi_control <= reg_wdata;
        if (mode_fault_flag_flag && !mode_fault_flag_seen)
        begin
          spi_control[spi_port_pkg::CR_PORT_OE] <= 1'b0;
          spi_control[spi_port_pkg::CR_MASTER]  <= 1'b0;
        end
      end
      // hardware clears enable and master on fault
      if (mode_fault_flag_event)
      begin
        spi_control[spi_port_pkg::CR_PORT_OE] <= 1'b0;
        spi_control[spi_port_pkg::CR_MASTER]  <= 1'b0;
      end
      if (mode_fault_flag_event)
        mode_fault_flag_flag <= 1'b1;
      else if (wr_ctrl && mode_fault_flag_seen)
        mode_fault_flag_flag <= 1'b0;
      if (complete)
      begin
        done_flag <= 1'b1;
        if (!done_flag)
          read_buf <= rx_byte;
      end
      else if (acc_data && csr_seen)
        done_flag <= 1'b0;
      if (complete && done_flag)
        ovr_flag <= 1'b1;
      else if (rd_csr)
        ovr_flag <= 1'b0;
      if (collide)
        write_collision_flag_flag <= 1'b1;
      else if (acc_data && csr_seen)
        write_collision_flag_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Read path
  wire [7:0] csr_view = {done_flag, write_collision_flag_flag, ovr_flag, mode_fault_flag_flag, 1'b0,
                         csr_sw[2:0]};
  logic [7:0] next_rdata;
  always_comb
  begin
    case (reg_addr)
      spi_port_pkg::IDX_DATA:    next_rdata = read_buf;
      spi_port_pkg::IDX_CONTROL: next_rdata = spi_control;
      spi_port_pkg::IDX_CSR:     next_rdata = csr_view;
      default:                   next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
  end

  // ==========================================================================
  // Pins and requests
  wire out_dis = csr_sw[spi_port_pkg::CS_OUT_DIS];
  wire tx_bit  = shift_reg[7];
  assign irq         = spi_control[spi_port_pkg::CR_IRQ_EN]
                       && (done_flag || mode_fault_flag_flag || ovr_flag);
  assign halt_wake   = spi_control[spi_port_pkg::CR_IRQ_EN] && done_flag
                       && !is_master;
  assign port_active = enabled;
  // master drives SCK at idle polarity
  assign sck_out     = clock_polarity ^ sck_int;
  assign sck_oe      = enabled && is_master;
  assign mosi_out    = tx_bit;
  assign mosi_oe     = enabled && is_master && !out_dis;
  assign miso_out    = tx_bit;
  assign miso_oe     = enabled && !is_master && !out_dis && !sel_n;

endmodule // spi_port

//--- test/spi_port_monitor.sv
`timescale 1ns/10ps
module spi_port_monitor
(
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq,
  input wire logic       halt_wake,
  input wire logic       sck_out,
  input wire logic       sck_oe,
  input wire logic       mosi_oe,
  input wire logic       miso_oe,
  input wire logic       select_n_in,
  input wire logic       port_active
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // ====
  // Pin directions
  chk_pins_gated:
    assert property (!port_active |-> !sck_oe && !mosi_oe && !miso_oe) else $error("pin driven");
  chk_master_dirs:
    assert property (sck_oe |-> !miso_oe) else $error("master drives miso");
  chk_slave_dirs:
    assert property (miso_oe |-> !sck_oe && !mosi_oe) else $error("slave drives clock");
  chk_sck_rate:
    assert property (sck_oe && $changed(sck_out) |=> $stable(sck_out)) else $error("sck fast");
  chk_fault_drop:
    assert property ((sck_oe && !select_n_in) [*3] |-> ##[0:3] !sck_oe) else $error("no fault");
  // ====
  // Events and bus
  chk_wake_irq:
    assert property (halt_wake |-> irq) else $error("wake without irq");
  chk_wake_slave:
    assert property (halt_wake |-> !sck_oe) else $error("wake in master");
  chk_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
  cov_wake: cover property ($rose(halt_wake));
  cov_fault: cover property ($fell(sck_oe));
  cov_slave: cover property ($rose(miso_oe));
endmodule // spi_port_monitor

bind spi_port spi_port_monitor u_mon (.clk_sys, .rstn, .reg_rd, .reg_rdata, .irq, .halt_wake,
  .sck_out, .sck_oe, .mosi_oe, .miso_oe, .select_n_in, .port_active);

//--- test/spi_far_slave.sv
`timescale 1ns/10ps
module spi_far_slave
(
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       clock_polarity,
  input  wire logic       clock_phase,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic      [7:0] rx_byte
);
  logic [3:0] idx = 4'h8;
  logic       lead;
  always @(posedge load)
  begin
    idx = 4'h0;
    rx_byte = 8'h00;
  end
  always @(sck)
  begin
    lead = (sck != clock_polarity);
    if (lead != clock_phase)
      rx_byte = {rx_byte[6:0], mosi};
    if (!lead && idx < 4'h8)
      idx = idx + 4'h1;
  end
  // Released line shows inverse of last bit
  assign miso = (idx < 4'h8) ? tx_byte[3'(4'h7 - idx)] : ~tx_byte[0];
endmodule // spi_far_slave

//--- test/spi_port_tb.sv
`timescale 1ns/10ps
module spi_port_tb;
  logic       clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0] reg_addr = 2'h0, mode = 2'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, far_tx = 8'h00, far_rx;
  logic       irq, halt_wake, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic       port_active, far_miso, tb_sck = 1'b0, tb_mosi = 1'b0;
  logic       select_n_in = 1'b1, far_load = 1'b0;
  wire        sck_in = sck_oe ? sck_out : tb_sck;
  wire        mosi_in = mosi_oe ? mosi_out : tb_mosi;
  int         err_count = 0, samples_checked = 0;
  always #10 clk_sys = ~clk_sys;
  spi_port u_dut (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .halt_wake, .sck_in, .sck_out, .sck_oe, .mosi_in, .mosi_out, .mosi_oe, .miso_in(far_miso),
    .miso_out, .miso_oe, .select_n_in, .port_active);
  spi_far_slave u_far (.sck(sck_in), .mosi(mosi_in), .clock_polarity(mode[1]), .clock_phase(mode[0]),
    .load(far_load), .tx_byte(far_tx), .miso(far_miso), .rx_byte(far_rx));
  // ====
  // Shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 3000)
    begin
      err_count++;
      $display("MISMATCH irq expected 1 seen timeout");
      end_sim;
    end
  endtask
  task automatic start(input logic [7:0] ctl);
    mode <= ctl[3:2];
    far_tx <= 8'h3C;
    wr(spi_port_pkg::IDX_CSR, 8'h00);
    wr(spi_port_pkg::IDX_CONTROL, ctl);
    far_load <= 1'b1;
    wr(spi_port_pkg::IDX_DATA, 8'hA5);
    far_load <= 1'b0;
  endtask
  task automatic finish(input logic [7:0] csr_exp, input logic [7:0] rx_exp);
    logic [7:0] d;
    rd(spi_port_pkg::IDX_CSR, d);
    chk(d, csr_exp, "status");
    rd(spi_port_pkg::IDX_DATA, d);
    chk(d, rx_exp, "rx data");
    rd(spi_port_pkg::IDX_CSR, d);
    chk(d & 8'hF0, 8'h00, "flags clear");
    chk({7'h00, irq}, 8'h00, "irq clear");
  endtask
  task automatic slave_byte(input logic [7:0] b, output logic [7:0] got);
    for (int i = 7; i >= 0; i--)
    begin
      tb_mosi <= b[i];
      repeat (8) @(posedge clk_sys);
      got[i] = miso_out;
      tb_sck <= 1'b1;
      repeat (8) @(posedge clk_sys);
      tb_sck <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
  endtask
  // ====
  // Scenarios
  task automatic t_reset;
    logic [7:0] d;
    for (int a = 0; a < 4; a++)
    begin
      rd(2'(a), d);
      chk(d, 8'h00, "reset value");
    end
    chk({6'h00, port_active, sck_oe}, 8'h00, "reset pins");
  endtask
  task automatic t_rates;
    logic [2:0] code [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
    int         n;
    for (int i = 0; i < 6; i++)
    begin
      start({2'b11, code[i][2], 1'b1, 2'(i), code[i][1:0]});
      chk({7'h00, sck_out}, {7'h00, mode[1]}, "sck idle");
      n = 0;
      while (sck_out === mode[1] && n < 300)
      begin
        @(posedge clk_sys);
        n++;
      end
      n = 0;
      while (sck_out !== mode[1] && n < 300)
      begin
        @(posedge clk_sys);
        n++;
      end
      chk(8'(n), 8'h02 << i, "sck half period");
      wait_irq;
      chk(far_rx, 8'hA5, "far rx");
      finish(8'h80, 8'h3C);
    end
  endtask
  task automatic t_refuse;
    start(8'hD0);
    repeat (3) @(posedge clk_sys);
    wr(spi_port_pkg::IDX_DATA, 8'h77);
    wait_irq;
    chk(far_rx, 8'hA5, "far rx kept");
    wr(spi_port_pkg::IDX_DATA, 8'h11);
    repeat (4) @(posedge clk_sys);
    chk({7'h00, sck_out}, 8'h00, "no restart");
    finish(8'hC0, 8'h3C);
  endtask
  task automatic t_slave;
    logic [7:0] got;
    mode <= 2'h0;
    select_n_in <= 1'b0;
    wr(spi_port_pkg::IDX_CONTROL, 8'hE3);
    wr(spi_port_pkg::IDX_DATA, 8'h96);
    slave_byte(8'h5A, got);
    chk(got, 8'h96, "slave tx");
    chk({6'h00, halt_wake, miso_oe}, 8'h03, "slave wake");
    slave_byte(8'hC3, got);
    finish(8'hA0, 8'h5A);
    select_n_in <= 1'b1;
    wr(spi_port_pkg::IDX_CSR, 8'h02);
    slave_byte(8'h81, got);
    finish(8'h82, 8'h81);
  endtask
  task automatic t_fault;
    logic [7:0] d;
    wr(spi_port_pkg::IDX_CSR, 8'h04);
    wr(spi_port_pkg::IDX_CONTROL, 8'hD0);
    @(posedge clk_sys);
    chk({6'h00, sck_oe, mosi_oe}, 8'h02, "output off");
    select_n_in <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk({5'h00, irq, halt_wake, port_active}, 8'h04, "fault pins");
    select_n_in <= 1'b1;
    rd(spi_port_pkg::IDX_CSR, d);
    chk(d, 8'h14, "fault flag");
    rd(spi_port_pkg::IDX_CONTROL, d);
    chk(d, 8'h80, "fault control");
    wr(spi_port_pkg::IDX_CONTROL, 8'h00);
    rd(spi_port_pkg::IDX_CSR, d);
    chk(d, 8'h04, "fault clear");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    $display("reset test done");
    t_rates;
    $display("rate test done");
    t_refuse;
    $display("refuse test done");
    t_slave;
    $display("slave test done");
    t_fault;
    $display("fault test done");
    end_sim;
  end
endmodule // spi_port_tb
